/* File: verif/icc_asserts.sv */
// checker: register answers and output timing of the capture unit
`timescale 1ns/10ps
`default_nettype none
module icc_asserts #(
  parameter int unsigned NCH = 4,
  parameter int unsigned W   = 16
) (
  input wire logic           ref_clk_in,
  input wire logic           rst_in,
  input wire logic           psel_in,
  input wire logic           penable_in,
  input wire logic           pwrite_in,
  input wire logic [7:0]     paddr_in,
  input wire logic           capture_in_a_in,
  input wire logic           capture_in_b_in,
  input wire logic           capture_in_c_in,
  input wire logic           capture_in_d_in,
  input wire logic [W-1:0]   first_timer_in,
  input wire logic [W-1:0]   second_timer_in,
  input wire logic [31:0]    prdata_out,
  input wire logic           pready_out,
  input wire logic           pslverr_out,
  input wire logic [NCH-1:0] capture_irq_out,
  input wire logic           wake_out
);
  logic [3:0] pins;
  logic [3:0] pins_q;
  logic [3:0] quiet;
  assign pins = {capture_in_d_in, capture_in_c_in, capture_in_b_in, capture_in_a_in};
  // cycles since the last pin change, saturating
  always_ff @(posedge ref_clk_in) begin
    pins_q <= pins;
    if (rst_in) quiet <= 4'hf;
    else quiet <= (pins != pins_q) ? 4'h0 : ((quiet == 4'hf) ? quiet : quiet + 4'h1);
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);
  property p_ready; psel_in && penable_in && !pready_out |=> pready_out; endproperty
  a_ready: assert property (p_ready) else $error("pready late");
  property p_ready_once; pready_out |-> $past(psel_in && penable_in && !pready_out); endproperty
  a_ready_once: assert property (p_ready_once) else $error("pready without wait cycle");
  property p_err_cause; pslverr_out |-> $past(psel_in && penable_in); endproperty
  a_err_cause: assert property (p_err_cause) else $error("error without access");
  property p_err_map; psel_in && penable_in && !pready_out && paddr_in > icc_pkg::STATUS_OFS |=> pslverr_out; endproperty
  a_err_map: assert property (p_err_map) else $error("unmapped access not refused");
  property p_rd_ok;
    psel_in && penable_in && !pready_out && !pwrite_in && paddr_in <= icc_pkg::STATUS_OFS
      && paddr_in[1:0] == 2'h0 |=> !pslverr_out;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("mapped read refused");
  property p_err_zero; pslverr_out && !$past(pwrite_in) |-> prdata_out == 32'h0000_0000; endproperty
  a_err_zero: assert property (p_err_zero) else $error("refused read data not zero");
  property p_timer;
    psel_in && penable_in && !pready_out && !pwrite_in && paddr_in == icc_pkg::TIMER_OFS
      |=> prdata_out == {$past(second_timer_in), $past(first_timer_in)};
  endproperty
  a_timer: assert property (p_timer) else $error("timer read wrong");
  property p_rst; $fell(rst_in) |-> capture_irq_out == '0 && !wake_out && !pslverr_out; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
  property p_wake; wake_out |-> quiet <= 4'h2; endproperty
  a_wake: assert property (p_wake) else $error("wake without fresh pin edge");
  property p_edge; capture_irq_out != '0 |-> quiet < 4'h8; endproperty
  a_edge: assert property (p_edge) else $error("irq without recent pin edge");
endmodule
bind icc_top icc_asserts #(.NCH(NCH), .W(W)) icc_asserts_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in),
  .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
  .capture_in_a_in(capture_in_a_in), .capture_in_b_in(capture_in_b_in), .capture_in_c_in(capture_in_c_in),
  .capture_in_d_in(capture_in_d_in), .first_timer_in(first_timer_in), .second_timer_in(second_timer_in),
  .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
  .capture_irq_out(capture_irq_out), .wake_out(wake_out));
`default_nettype wire

/* File: verif/icc_pin_model.sv */
// model of the external signals on the four capture pins
`timescale 1ns/10ps
`default_nettype none
module icc_pin_model (
  input  wire logic       ref_clk_in,
  output var  logic [3:0] pins_out
);
  initial pins_out = 4'h0;
  // one edge on a pin, then quiet for gap cycles
  task automatic toggle(input int ch, input int gap);
    pins_out[ch] <= ~pins_out[ch];
    repeat (gap) @(posedge ref_clk_in);
  endtask
endmodule
`default_nettype wire

/* File: verif/icc_top_tb.sv */
// testbench: mode table, fifo fill and drain, register checks
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin n_fail++; $display("wrong value t=%0t %h/%h", $time, a, b); end end
module icc_top_tb;
  logic        ref_clk_in, rst_in, psel, penable, pwrite, pready, pslverr, wake;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] tmr_a, tmr_b;
  logic [3:0]  irq, pins, irq_en;
  logic [33:0] exp_q[$];
  logic [2:0]  modes[8] = '{3'h4, 3'h2, 3'h1, 3'h5, 3'h4, 3'h3, 3'h7, 3'h6};
  int          n_fail, num_checks, seed, nwake, nirq[4];
  icc_top icc_top_i (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel), .penable_in(penable),
    .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hf), .prdata_out(prdata),
    .pready_out(pready), .pslverr_out(pslverr), .capture_in_a_in(pins[0]), .capture_in_b_in(pins[1]),
    .capture_in_c_in(pins[2]), .capture_in_d_in(pins[3]), .first_timer_in(tmr_a),
    .second_timer_in(tmr_b), .irq_enable_in(irq_en), .capture_irq_out(irq), .wake_out(wake));
  icc_pin_model icc_pin_model_i (.ref_clk_in(ref_clk_in), .pins_out(pins));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  ////////////////////////////////////////////////////////////////
  // read data and error taken at the edge that samples pready high
  always @(posedge ref_clk_in) begin
    logic [33:0] e;
    if (psel && penable && pready) begin
      e = exp_q.pop_front();
      `CHK(pslverr, e[32])
      if (e[33]) `CHK(prdata, e[31:0])
    end
    for (int c = 0; c < 4; c++) nirq[c] += irq[c];
    nwake += wake;
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [33:0] e);
    exp_q.push_back(e);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk_in);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk_in);
    end while (pready !== 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d);
    apb(1'b0, a, 32'h0, {2'b10, d});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, {2'b00, 32'h0});
  endtask
  task automatic idle();
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk_in);
  endtask
  function automatic logic [7:0] ofs(input int c, input logic [7:0] o);
    return o + 8'(c) * icc_pkg::CHAN_STEP;
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    logic [2:0] m;
    logic [1:0] epi;
    logic ts, ovf, en;
    int ch, cnt, pc, nq, nw, bi, bw;
    logic [15:0] v[$];
    seed = 69;
    rst_in = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h0;
    pwdata = 32'h0;
    irq_en = 4'hf;
    tmr_a = 16'($random(seed));
    tmr_b = 16'($random(seed));
    repeat (5) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    @(posedge ref_clk_in);
    for (int c = 0; c < 4; c++) rd(ofs(c, icc_pkg::CTRL_OFS), 32'h0000_0080);
    rd(icc_pkg::STATUS_OFS, 32'h0);
    rd(icc_pkg::TIMER_OFS, {tmr_b, tmr_a});
    apb(1'b0, 8'h28, 32'h0, {2'b11, 32'h0});
    apb(1'b1, 8'hfc, 32'hffff_ffff, {2'b01, 32'h0});
    for (int i = 0; i < 8; i++) begin
      ch = i % 4;
      m = modes[i];
      ts = 1'($random(seed));
      epi = (m == 3'h4 || m == 3'h5) ? 2'h0 : (($random(seed) & 1) ? 2'h3 : 2'h1);
      en = (i == 6) | 1'($random(seed));
      wr(ofs(ch, icc_pkg::CTRL_OFS), {24'h0, ts, epi, 2'h0, m});
      idle();
      irq_en <= {4{en}};
      cnt = 0;
      pc = 0;
      nq = 0;
      nw = 0;
      ovf = 1'b0;
      v.delete();
      bi = nirq[ch];
      bw = nwake;
      for (int k = 0; k < 12; k++) begin
        logic rise, q;
        logic [15:0] a, b;
        a = 16'($random(seed));
        b = 16'($random(seed));
        rise = (k % 2 == 0);
        if (rise && (m == 3'h4 || m == 3'h5)) pc++;
        q = (m == 3'h1) || (m == 3'h2 && !rise) || ((m == 3'h3 || m == 3'h7) && rise)
          || (m == 3'h4 && rise && pc % 4 == 0) || (m == 3'h5 && rise && pc % 16 == 0);
        if (q && m == 3'h1) nq++;
        if (q && m == 3'h7) nw++;
        if (q && cnt == 4 && m != 3'h1) ovf = 1'b1;
        else if (q && !ovf && cnt < 4) begin
          cnt++;
          v.push_back(ts ? b : a);
          if (m != 3'h1 && cnt % (epi + 1) == 0) nq++;
        end
        tmr_a <= a;
        tmr_b <= b;
        icc_pin_model_i.toggle(ch, 6 + ($random(seed) & 3));
      end
      `CHK(nirq[ch] - bi, en ? nq : 0)
      `CHK(nwake - bw, en ? nw : 0)
      rd(ofs(ch, icc_pkg::CTRL_OFS), {24'h0, ts, epi, ovf, cnt > 0, m});
      rd(icc_pkg::STATUS_OFS, 32'({ovf, 3'h0, cnt > 0}) << ch);
      foreach (v[j]) rd(ofs(ch, icc_pkg::BUF_OFS), {16'h0, v[j]});
      rd(ofs(ch, icc_pkg::CTRL_OFS), {24'h0, ts, epi, 2'h0, m});
      wr(ofs(ch, icc_pkg::CTRL_OFS), 32'h0);
      idle();
    end
    final_report();
  end
  initial begin
    repeat (6000) @(posedge ref_clk_in);
    n_fail++;
    final_report();
  end
endmodule
`default_nettype wire

/* File: verilog/icc_channel.sv */
// one capture channel: edge detect, prescaler, four-word fifo, flags
`timescale 1ns/10ps
`default_nettype none
module icc_channel #(
  parameter int unsigned DEPTH = icc_pkg::FIFO_DEPTH,
  parameter int unsigned W     = icc_pkg::CNT_W
) (
  input  wire logic             ref_clk_in,
  input  wire logic             rst_in,
  input  wire logic             pin_sync_in,
  input  wire icc_pkg::icc_cfg_t cfg_in,
  input  wire logic [W-1:0]     first_timer_in,
  input  wire logic [W-1:0]     second_timer_in,
  input  wire logic             pop_in,
  output var  icc_pkg::icc_stat_t stat_out
);
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic              prev_pin;
  logic [3:0]        pre_cnt;
  logic [1:0]        irq_cnt;
  logic [W-1:0]      mem [DEPTH];
  logic [CW-1:0]     count;
  logic              ovf;
  logic              irq;
  logic              next_prev_pin;
  logic [3:0]        next_pre_cnt;
  logic [1:0]        next_irq_cnt;
  logic [W-1:0]      next_mem [DEPTH];
  logic [CW-1:0]     next_count;
  logic              next_ovf;
  logic              next_irq;
  logic              rise;
  logic              fall;
  logic              event_q;
  logic [W-1:0]      stamp;

  always_comb begin
    rise  = pin_sync_in & ~prev_pin;
    fall  = ~pin_sync_in & prev_pin;
    stamp = cfg_in.time_base_sel ? second_timer_in : first_timer_in;
    next_pre_cnt = pre_cnt;
    event_q      = 1'b0;
    unique case (cfg_in.capture_mode_sel)
      icc_pkg::ICC_MODE_OFF:    next_pre_cnt = 4'h0;
      icc_pkg::ICC_MODE_BOTH:   event_q = rise | fall;
      icc_pkg::ICC_MODE_FALL:   event_q = fall;
      icc_pkg::ICC_MODE_RISE,
      icc_pkg::ICC_MODE_WAKE:   event_q = rise;
      icc_pkg::ICC_MODE_RISE4: begin
        if (rise) begin
          event_q      = (pre_cnt[1:0] == icc_pkg::PRE4_LAST[1:0]);
          next_pre_cnt = event_q ? 4'h0 : pre_cnt + 4'h1;
        end
      end
      icc_pkg::ICC_MODE_RISE16: begin
        if (rise) begin
          event_q      = (pre_cnt == icc_pkg::PRE16_LAST);
          next_pre_cnt = pre_cnt + 4'h1;
        end
      end
      default: event_q = 1'b0;
    endcase

    next_prev_pin = pin_sync_in;
    next_mem      = mem;
    next_count    = count;
    next_ovf      = ovf;
    next_irq      = 1'b0;
    next_irq_cnt  = irq_cnt;
    if (pop_in && count != '0) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        next_mem[i] = mem[i + 1];
      end
      next_count = count - CW'(1);
    end
    if (pop_in && count == CW'(1)) begin
      next_ovf = 1'b0;
    end
    if (event_q) begin
      if (cfg_in.capture_mode_sel == icc_pkg::ICC_MODE_BOTH) begin
        next_irq = 1'b1;
      end else begin
        next_irq_cnt = irq_cnt + 2'h1;
        if (irq_cnt == cfg_in.events_per_irq) begin
          next_irq     = 1'b1;
          next_irq_cnt = 2'h0;
        end
      end
      if (ovf) begin
        next_irq = 1'b0;
        next_irq_cnt = irq_cnt;
      end else if (next_count == CW'(DEPTH)) begin
        if (cfg_in.capture_mode_sel != icc_pkg::ICC_MODE_BOTH) begin
          next_ovf = 1'b1;
        end
      end else begin
        next_mem[next_count[CW-2:0]] = stamp;
        next_count = next_count + CW'(1);
      end
    end
    if (cfg_in.capture_mode_sel == icc_pkg::ICC_MODE_OFF) begin
      next_irq_cnt = 2'h0;
    end
    if (rst_in) begin
      next_prev_pin = 1'b0;
      next_pre_cnt  = 4'h0;
      next_irq_cnt  = 2'h0;
      next_count    = '0;
      next_ovf      = 1'b0;
      next_irq      = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
        next_mem[i] = '0;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    prev_pin <= next_prev_pin;
    pre_cnt  <= next_pre_cnt;
    irq_cnt  <= next_irq_cnt;
    mem      <= next_mem;
    count    <= next_count;
    ovf      <= next_ovf;
    irq      <= next_irq;
  end

  always_comb begin
    stat_out.buf_not_empty    = (count != '0);
    stat_out.capture_overflow = ovf;
    stat_out.irq              = irq;
    stat_out.head             = mem[0];
  end
endmodule
`default_nettype wire

/* File: verilog/icc_pkg.sv */
// package: register map, field layout and mode codes of the capture unit
package icc_pkg;

  localparam int unsigned NUM_CHAN   = 4;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned CNT_W      = 16;

  // byte offsets, per channel stride of two words
  localparam logic [7:0] BUF_OFS    = 8'h00;
  localparam logic [7:0] CTRL_OFS   = 8'h04;
  localparam logic [7:0] CHAN_STEP  = 8'h08;
  localparam logic [7:0] TIMER_OFS  = 8'h20;
  localparam logic [7:0] STATUS_OFS = 8'h24;

  // control register fields
  localparam int unsigned MODE_LSB   = 0;
  localparam int unsigned BNE_BIT    = 3;
  localparam int unsigned OV_BIT     = 4;
  localparam int unsigned EPI_LSB    = 5;
  localparam int unsigned TSEL_BIT   = 7;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  localparam logic [3:0] PRE4_LAST  = 4'h3;
  localparam logic [3:0] PRE16_LAST = 4'hf;

  typedef enum logic [2:0] {
    ICC_MODE_OFF   = 3'h0,
    ICC_MODE_BOTH  = 3'h1,
    ICC_MODE_FALL  = 3'h2,
    ICC_MODE_RISE  = 3'h3,
    ICC_MODE_RISE4 = 3'h4,
    ICC_MODE_RISE16 = 3'h5,
    ICC_MODE_RSVD  = 3'h6,
    ICC_MODE_WAKE  = 3'h7
  } icc_mode_t;

  typedef struct packed {
    logic       time_base_sel;
    logic [1:0] events_per_irq;
    icc_mode_t  capture_mode_sel;
  } icc_cfg_t;

  typedef struct packed {
    logic        buf_not_empty;
    logic        capture_overflow;
    logic        irq;
    logic [15:0] head;
  } icc_stat_t;

endpackage

/* File: verilog/icc_sync.sv */
// two-stage synchroniser for one asynchronous level
`timescale 1ns/10ps
`default_nettype none
module icc_sync (
  input  wire logic ref_clk_in,
  input  wire logic rst_in,
  input  wire logic async_in,
  output var  logic sync_out
);
  logic meta;
  logic next_meta;
  logic next_sync;

  always_comb begin
    next_meta = rst_in ? 1'b0 : async_in;
    next_sync = rst_in ? 1'b0 : meta;
  end

  always_ff @(posedge ref_clk_in) begin
    meta     <= next_meta;
    sync_out <= next_sync;
  end
endmodule
`default_nettype wire

/* File: verilog/icc_top.sv */
// four-channel input capture unit with apb register slave
`timescale 1ns/10ps
`default_nettype none
module icc_top #(
  parameter int unsigned NCH = icc_pkg::NUM_CHAN,
  parameter int unsigned W   = icc_pkg::CNT_W
) (
  input  wire logic          ref_clk_in,
  input  wire logic          rst_in,
  input  wire logic          psel_in,
  input  wire logic          penable_in,
  input  wire logic          pwrite_in,
  input  wire logic [7:0]    paddr_in,
  input  wire logic [31:0]   pwdata_in,
  input  wire logic [3:0]    pstrb_in,
  output var  logic [31:0]   prdata_out,
  output logic               pready_out,
  output var  logic          pslverr_out,
  input  wire logic          capture_in_a_in,
  input  wire logic          capture_in_b_in,
  input  wire logic          capture_in_c_in,
  input  wire logic          capture_in_d_in,
  input  wire logic [W-1:0]  first_timer_in,
  input  wire logic [W-1:0]  second_timer_in,
  input  wire logic [NCH-1:0] irq_enable_in,
  output var  logic [NCH-1:0] capture_irq_out,
  output var  logic          wake_out
);
  //////////////////////////////////////////////////////////////////////////////
  logic [3:0]                pins;
  logic [NCH-1:0]            pin_sync;
  icc_pkg::icc_cfg_t         cfg [NCH];
  icc_pkg::icc_cfg_t         next_cfg [NCH];
  icc_pkg::icc_stat_t        stat [NCH];
  logic [NCH-1:0]            pop;
  logic [31:0]               next_prdata;
  logic                      next_pslverr;
  logic [NCH-1:0]            next_irq_out;
  logic                      next_wake;
  logic                      access;
  logic                      ready_q;
  logic                      next_ready;
  logic [NCH-1:0]            pin_prev;
  logic [NCH-1:0]            next_pin_prev;

  assign pins       = {capture_in_d_in, capture_in_c_in, capture_in_b_in, capture_in_a_in};
  assign pready_out = ready_q;
  assign access     = psel_in & penable_in;

  //////////////////////////////////////////////////////////////////////////////
  for (genvar c = 0; c < NCH; c++) begin : g_ch
    icc_sync u_sync (
      .ref_clk_in (ref_clk_in),
      .rst_in     (rst_in),
      .async_in   (pins[c]),
      .sync_out   (pin_sync[c])
    );
    icc_channel #(
      .DEPTH (icc_pkg::FIFO_DEPTH),
      .W     (W)
    ) u_ch (
      .ref_clk_in      (ref_clk_in),
      .rst_in          (rst_in),
      .pin_sync_in     (pin_sync[c]),
      .cfg_in          (cfg[c]),
      .first_timer_in  (first_timer_in),
      .second_timer_in (second_timer_in),
      .pop_in          (pop[c]),
      .stat_out        (stat[c])
    );
  end

  //////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_cfg     = cfg;
    next_prdata  = prdata_out;
    next_pslverr = 1'b0;
    pop          = '0;
    if (access) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b1;
      for (int c = 0; c < NCH; c++) begin
        if (paddr_in == 8'(icc_pkg::BUF_OFS + 8'(c) * icc_pkg::CHAN_STEP)) begin
          next_pslverr = 1'b0;
          if (!pwrite_in) begin
            next_prdata[W-1:0] = stat[c].head;
            pop[c]             = 1'b1;
          end
        end
        if (paddr_in == 8'(icc_pkg::CTRL_OFS + 8'(c) * icc_pkg::CHAN_STEP)) begin
          next_pslverr = 1'b0;
          if (pwrite_in) begin
            if (pstrb_in[0]) begin
              next_cfg[c].capture_mode_sel =
                icc_pkg::icc_mode_t'(pwdata_in[icc_pkg::MODE_LSB +: 3]);
              next_cfg[c].events_per_irq   = pwdata_in[icc_pkg::EPI_LSB +: 2];
              next_cfg[c].time_base_sel    = pwdata_in[icc_pkg::TSEL_BIT];
            end
          end else begin
            next_prdata[icc_pkg::MODE_LSB +: 3] = cfg[c].capture_mode_sel;
            next_prdata[icc_pkg::BNE_BIT]       = stat[c].buf_not_empty;
            next_prdata[icc_pkg::OV_BIT]        = stat[c].capture_overflow;
            next_prdata[icc_pkg::EPI_LSB +: 2]  = cfg[c].events_per_irq;
            next_prdata[icc_pkg::TSEL_BIT]      = cfg[c].time_base_sel;
          end
        end
      end
      if (paddr_in == icc_pkg::TIMER_OFS) begin
        next_pslverr = 1'b0;
        next_prdata  = {second_timer_in, first_timer_in};
      end
      if (paddr_in == icc_pkg::STATUS_OFS) begin
        next_pslverr = 1'b0;
        for (int c = 0; c < NCH; c++) begin
          next_prdata[c]       = stat[c].buf_not_empty;
          next_prdata[c + NCH] = stat[c].capture_overflow;
        end
      end
    end
    // one wait state: answer registered in the first access cycle,
    // writes and pops only at the edge that sees pready high
    next_ready = access & ~ready_q;
    if (!next_ready) begin
      next_prdata  = prdata_out;
      next_pslverr = 1'b0;
    end
    if (!(access && ready_q)) begin
      next_cfg = cfg;
      pop      = '0;
    end
    if (rst_in) begin
      for (int c = 0; c < NCH; c++) begin
        next_cfg[c].capture_mode_sel = icc_pkg::icc_mode_t'(icc_pkg::CTRL_RESET[icc_pkg::MODE_LSB +: 3]);
        next_cfg[c].events_per_irq   = icc_pkg::CTRL_RESET[icc_pkg::EPI_LSB +: 2];
        next_cfg[c].time_base_sel    = 1'b1;
      end
      next_prdata  = 32'h0000_0000;
      next_pslverr = 1'b0;
      next_ready   = 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // wake on every rising edge of a channel in wake mode with its irq enable set, independent of irq grouping and fifo state
  always_comb begin
    next_wake     = 1'b0;
    next_pin_prev = pin_sync;
    for (int c = 0; c < NCH; c++) begin
      next_irq_out[c] = stat[c].irq & irq_enable_in[c];
      if (cfg[c].capture_mode_sel == icc_pkg::ICC_MODE_WAKE && irq_enable_in[c] && pin_sync[c] && !pin_prev[c]) begin
        next_wake = 1'b1;
      end
    end
    if (rst_in) begin
      next_irq_out  = '0;
      next_wake     = 1'b0;
      next_pin_prev = '0;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    cfg             <= next_cfg;
    prdata_out      <= next_prdata;
    pslverr_out     <= next_pslverr;
    capture_irq_out <= next_irq_out;
    wake_out        <= next_wake;
    ready_q         <= next_ready;
    pin_prev        <= next_pin_prev;
  end
endmodule
`default_nettype wire
